// [rtl/chain_defs.svh]
`ifndef CHAIN_DEFS_SVH
`define CHAIN_DEFS_SVH

// ****************************************
// Time base
// ****************************************
`define CLK_PERIOD_NS   10
`define MS_PERIOD_NS    1000000
`define HOLD_CW         14

// ****************************************
// Hold times in ms per strap code
// ****************************************
`define HOLD_MS_0       14'd0
`define HOLD_MS_1       14'd80
`define HOLD_MS_2       14'd625
`define HOLD_MS_3       14'd1250
`define HOLD_MS_4       14'd2500
`define HOLD_MS_5       14'd5000
`define HOLD_MS_6       14'd10000
`define HOLD_MS_7       14'd10000

// ****************************************
// Self-test durations in ms
// ****************************************
`define ST_FAST_MS      14'd25
`define ST_SLOW_MS      14'd1000

// ****************************************
// Register map
// ****************************************
`define APB_AW          12
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_HOLD        12'h008
`define CTRL_RESET      3'h0

`endif

// [rtl/chain_pkg.sv]
package chain_pkg;

    // Order follows the {head, base} strap code
    typedef enum logic [1:0] {pos_middle, pos_base, pos_head, pos_single} pos_t;

    typedef enum logic [1:0] {st_idle, st_run, st_done} st_state_t;

endpackage : chain_pkg

// [rtl/sync2.sv]
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] dout_reg;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            dout_reg <= '0;
        end
        else
        begin
            meta_reg <= din;
            dout_reg <= meta_reg;
        end
    end

    assign dout = dout_reg;

endmodule : sync2

`default_nettype wire

// [rtl/hold_filter.sv]
`timescale 1ns/1ps
`default_nettype none

module hold_filter #(
    parameter int CW = 14
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          ms_tick,
    input  wire logic          cond,
    input  wire logic [CW-1:0] hold_ms,
    output logic               alarm
);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          alarm_reg;
    logic          alarm_next;
    logic          hit;

    // Saturating count so a long fault never wraps back below the hold
    assign cnt_next   = !cond ? '0 :
                        (ms_tick && cnt_reg != {CW{1'b1}}) ? cnt_reg + 1'b1 : cnt_reg;
    // Strictly past the hold: the first tick can land just after the condition rose
    assign hit        = (hold_ms == '0) || (cnt_reg > hold_ms);
    assign alarm_next = cond && hit;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_reg   <= '0;
            alarm_reg <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            alarm_reg <= alarm_next;
        end
    end

    assign alarm = alarm_reg;

    a_hold_met: assert property (@(posedge mclk) disable iff (rst)
        alarm_reg |-> ($past(hold_ms) == '0 || $past(cnt_reg) > $past(hold_ms)))
        else $error("alarm raised before hold time");

    a_drop_clear: assert property (@(posedge mclk) disable iff (rst)
        !cond |=> !alarm_reg && cnt_reg == '0)
        else $error("alarm or count survived a cleared condition");

endmodule : hold_filter

`default_nettype wire

// [rtl/cell_alarm_chain_monitor.sv]
// Functional notes
// - Two straps decode chain position.
// - Base device takes controller wake and test.
// - Middle takes from-up alarms, forwards requests.
// - Alarms combine own and upstream status.
// - Split mode: independent high, low, heat.
// - Shared mode: any condition drives all three.
// - Alarm only after condition persists hold time.
// - Hold time decoded from three code straps.
// - Low wake means standby, rails off.
// - Wake state forwarded up the chain.
// - Alarm high when alarmed; passed downward.
// - Check rising edge starts self-test, outputs show it.
// - Test drives outputs high; low on pass.
// - Test lasts 25 ms or 1000 ms.
// - Forward test request and start at once.
// - Pass downward needs own and upstream pass.
// - Any failure keeps base outputs high.
// - Slope select picks below or above trip.
// - Split mode test result covers own condition.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "chain_defs.svh"

module cell_alarm_chain_monitor
    import chain_pkg::*;
#(
    parameter int NCELL      = 6,
    parameter int NTEMP      = 2,
    parameter int MS_CYCLES  = `MS_PERIOD_NS / `CLK_PERIOD_NS
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 chain_head_strap,
    input  wire logic                 chain_base_strap,
    input  wire logic                 hold_code_b0,
    input  wire logic                 hold_code_b1,
    input  wire logic                 hold_code_b2,
    input  wire logic                 alarm_split_sel,
    input  wire logic                 thermistor_slope_sel,
    input  wire logic                 wake_in,
    input  wire logic                 check_req_in,
    input  wire logic                 high_cell_flag_from_up,
    input  wire logic                 low_cell_flag_from_up,
    input  wire logic                 heat_flag_from_up,
    input  wire logic [NCELL-1:0]     high_cell_cond,
    input  wire logic [NCELL-1:0]     low_cell_cond,
    input  wire logic [NTEMP-1:0]     heat_above_trip,
    output logic                      high_cell_flag_level,
    output logic                      low_cell_flag_level,
    output logic                      heat_flag_level,
    output logic                      high_cell_flag_sink_dn,
    output logic                      low_cell_flag_sink_dn,
    output logic                      heat_flag_sink_dn,
    output logic                      wake_fwd_out,
    output logic                      check_req_fwd,
    output logic                      rail_enable,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [`APB_AW-1:0]   paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr
);

    localparam int CW = `HOLD_CW;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [11:0] pin_s;
    logic        head_s;
    logic        base_s;
    logic [2:0]  code_s;
    logic        split_s;
    logic        slope_s;
    logic        wake_s;
    logic        chk_s;
    logic [2:0]  up_s;

    sync2 #(.W(12)) u_pin_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  ({chain_head_strap, chain_base_strap, hold_code_b2, hold_code_b1,
                hold_code_b0, alarm_split_sel, thermistor_slope_sel, wake_in,
                check_req_in, heat_flag_from_up, low_cell_flag_from_up,
                high_cell_flag_from_up}),
        .dout (pin_s)
    );

    assign head_s  = pin_s[11];
    assign base_s  = pin_s[10];
    assign code_s  = {pin_s[7], pin_s[8], pin_s[9]};
    assign split_s = pin_s[6];
    assign slope_s = pin_s[5];
    assign wake_s  = pin_s[4];
    assign chk_s   = pin_s[3];
    assign up_s    = pin_s[2:0];

    // ****************************************
    // Position and hold decode
    // ****************************************
    pos_t          pos_reg;
    pos_t          pos_next;
    logic [CW-1:0] hold_ms_reg;
    logic [CW-1:0] hold_ms_next;
    logic          up_ignored;

    assign pos_next = pos_t'({head_s, base_s});
    assign up_ignored = (pos_reg == pos_head) || (pos_reg == pos_single);

    // Code 111 is not for board use; it falls back to the longest hold
    assign hold_ms_next = (code_s == 3'h0) ? `HOLD_MS_0 :
                          (code_s == 3'h1) ? `HOLD_MS_1 :
                          (code_s == 3'h2) ? `HOLD_MS_2 :
                          (code_s == 3'h3) ? `HOLD_MS_3 :
                          (code_s == 3'h4) ? `HOLD_MS_4 :
                          (code_s == 3'h5) ? `HOLD_MS_5 :
                          (code_s == 3'h6) ? `HOLD_MS_6 : `HOLD_MS_7;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pos_reg     <= pos_single;
            hold_ms_reg <= `HOLD_MS_0;
        end
        else
        begin
            pos_reg     <= pos_next;
            hold_ms_reg <= hold_ms_next;
        end
    end

    // ****************************************
    // Millisecond time base
    // ****************************************
    logic [31:0] div_reg;
    logic        ms_tick;

    assign ms_tick = (div_reg == 32'(MS_CYCLES - 1));

    always_ff @(posedge mclk)
    begin
        if (rst || ms_tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + 32'h1;
    end

    // ****************************************
    // Conditions and hold filters
    // ****************************************
    logic [NTEMP-1:0] heat_hit;
    logic [2:0]       cond_vec;
    logic [2:0]       own_alarm;
    logic [2:0]       up_eff;

    assign heat_hit = slope_s ? heat_above_trip : ~heat_above_trip;
    // Standby clears every filter so no stale alarm survives wake-up
    assign cond_vec = {|heat_hit, |low_cell_cond, |high_cell_cond} & {3{wake_s}};
    assign up_eff   = up_ignored ? 3'h0 : up_s;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_filt
            hold_filter #(.CW(CW)) u_filt (
                .mclk    (mclk),
                .rst     (rst),
                .ms_tick (ms_tick),
                .cond    (cond_vec[gi]),
                .hold_ms (hold_ms_reg),
                .alarm   (own_alarm[gi])
            );
        end
    endgenerate

    // ****************************************
    // Self-test sequencer
    // ****************************************
    st_state_t     st_reg;
    st_state_t     st_next;
    logic [CW-1:0] st_ms_reg;
    logic [CW-1:0] st_ms_next;
    logic [CW-1:0] test_len;
    logic [2:0]    seen_reg;
    logic [2:0]    seen_next;
    logic          chk_d_reg;
    logic          chk_rise;
    logic [2:0]    ctrl_reg;

    assign chk_rise = chk_s && !chk_d_reg && wake_s;
    // The slow test is used whenever the strapped hold is not 0 ms
    assign test_len = (hold_ms_reg == `HOLD_MS_0) ? `ST_FAST_MS : `ST_SLOW_MS;

    always_comb
    begin
        st_next    = st_reg;
        st_ms_next = st_ms_reg;
        seen_next  = seen_reg;
        case (st_reg)
            st_idle:
            begin
                if (chk_rise)
                begin
                    st_next    = st_run;
                    st_ms_next = '0;
                    seen_next  = cond_vec;
                end
            end
            st_run:
            begin
                seen_next = seen_reg | cond_vec;
                if (ms_tick)
                    st_ms_next = st_ms_reg + 1'b1;
                if (st_ms_reg >= test_len)
                    st_next = st_done;
                if (!chk_s)
                    st_next = st_idle;
            end
            st_done:
            begin
                if (!chk_s)
                    st_next = st_idle;
            end
            default:
                st_next = st_idle;
        endcase
        if (!wake_s)
            st_next = st_idle;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_reg    <= st_idle;
            st_ms_reg <= '0;
            seen_reg  <= 3'h0;
            chk_d_reg <= 1'b0;
        end
        else
        begin
            st_reg    <= st_next;
            st_ms_reg <= st_ms_next;
            seen_reg  <= seen_next;
            chk_d_reg <= chk_s;
        end
    end

    // ****************************************
    // Output combining
    // ****************************************
    logic [2:0] own_pass;
    logic [2:0] pass_all;
    logic [2:0] norm_out;
    logic [2:0] test_out;
    logic [2:0] lvl_next;
    logic [2:0] lvl_reg;
    logic [2:0] sink_reg;
    logic       wake_fwd_reg;
    logic       chk_fwd_reg;
    logic       rail_reg;

    // A fault injected from software, or a live condition, fails the test
    assign own_pass = ~(seen_reg | ctrl_reg);
    assign pass_all = split_s ? (own_pass & ~up_eff)
                              : {3{&own_pass && !(|up_eff)}};
    assign norm_out = split_s ? (own_alarm | up_eff)
                              : {3{|own_alarm || |up_eff}};
    assign test_out = (st_reg == st_run) ? 3'h7 : ~pass_all;
    assign lvl_next = !wake_s ? 3'h0 :
                      (st_reg != st_idle) ? test_out : norm_out;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            lvl_reg      <= 3'h0;
            sink_reg     <= 3'h0;
            wake_fwd_reg <= 1'b0;
            chk_fwd_reg  <= 1'b0;
            rail_reg     <= 1'b0;
        end
        else
        begin
            lvl_reg      <= lvl_next;
            sink_reg     <= lvl_next;
            wake_fwd_reg <= wake_s;
            chk_fwd_reg  <= chk_s && wake_s;
            rail_reg     <= wake_s;
        end
    end

    assign high_cell_flag_level   = lvl_reg[0];
    assign low_cell_flag_level    = lvl_reg[1];
    assign heat_flag_level        = lvl_reg[2];
    assign high_cell_flag_sink_dn = sink_reg[0];
    assign low_cell_flag_sink_dn  = sink_reg[1];
    assign heat_flag_sink_dn      = sink_reg[2];
    assign wake_fwd_out           = wake_fwd_reg;
    assign check_req_fwd          = chk_fwd_reg;
    assign rail_enable            = rail_reg;

    // ****************************************
    // APB slave
    // ****************************************
    logic        apb_acc;
    logic        apb_fin;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_hold;
    logic        hit_any;
    logic [31:0] rd_mux;
    logic [31:0] stat_word;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;

    // One wait state: pready rises in the second access cycle
    assign apb_acc   = psel && penable && !pready_reg;
    assign apb_fin   = psel && penable && pready_reg;
    assign hit_ctrl  = (paddr == `REG_CTRL);
    assign hit_stat  = (paddr == `REG_STATUS);
    assign hit_hold  = (paddr == `REG_HOLD);
    assign hit_any   = hit_ctrl || hit_stat || hit_hold;
    assign stat_word = {18'h0, st_reg, seen_reg, lvl_reg, own_alarm, wake_s, pos_reg};
    assign rd_mux    = hit_ctrl ? {29'h0, ctrl_reg} :
                       hit_stat ? stat_word :
                       hit_hold ? {18'h0, hold_ms_reg} : 32'h0;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
            ctrl_reg    <= `CTRL_RESET;
        end
        else
        begin
            pready_reg  <= apb_acc;
            pslverr_reg <= apb_acc && !hit_any;
            prdata_reg  <= (apb_acc && !pwrite) ? rd_mux : 32'h0;
            if (apb_fin && pwrite && hit_ctrl)
                ctrl_reg <= pwdata[2:0];
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_test_start;
        $rose(chk_s) && wake_s && st_reg == st_idle;
    endsequence

    sequence s_outputs_high;
        lvl_reg == 3'h7 && sink_reg == 3'h7;
    endsequence

    a_pos_decode: assert property (!$past(rst)
        |-> pos_reg == pos_t'({$past(head_s), $past(base_s)}))
        else $error("position differs from straps");

    a_standby_off: assert property (!wake_s |=> !rail_enable && lvl_reg == 3'h0)
        else $error("standby left rails or alarms on");

    a_shared_same: assert property (!$past(split_s) |-> lvl_reg == {3{lvl_reg[0]}})
        else $error("shared outputs differ");

    a_split_low: assert property (split_s && wake_s && st_reg == st_idle
        |=> lvl_reg[1] == $past(own_alarm[1] | up_eff[1]))
        else $error("low alarm not independent in split mode");

    a_test_raise: assert property (s_test_start |=> ##1 s_outputs_high)
        else $error("self-test did not raise outputs");

    a_test_len: assert property (st_reg == st_run |-> st_ms_reg <= test_len)
        else $error("self-test overran its duration");

    a_fwd_check: assert property (s_test_start |=> check_req_fwd)
        else $error("test request not forwarded");

    a_pass_gated: assert property (st_reg == st_done && wake_s && !up_ignored && up_s[0]
        |=> high_cell_flag_level)
        else $error("pass reported without upstream pass");

    a_head_ignore: assert property (up_ignored && wake_s && st_reg == st_idle
        && own_alarm == 3'h0 |=> lvl_reg == 3'h0)
        else $error("head device used from-up inputs");

    a_sink_mirror: assert property (wake_s && st_reg == st_idle
        |=> (sink_reg & $past(own_alarm)) == $past(own_alarm))
        else $error("own alarm not passed downward");

endmodule : cell_alarm_chain_monitor

`default_nettype wire

// [verification/upper_monitor_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Behavioural monitor sitting above the block
// ****************************************
module upper_monitor_model #(
    parameter int DELAY = 60
) (
    input  wire logic       mclk,
    input  wire logic       wake,
    input  wire logic       check,
    input  wire logic [2:0] alarm,
    input  wire logic [2:0] fail,
    output logic      [2:0] flags
);
    int   cnt = 0;
    logic check_d = 1'h0;

    // Pass is withheld until its own test time has run
    always @(posedge mclk)
    begin
        check_d <= check;
        if (!wake)
            flags <= 3'h0;
        else if (check && !check_d)
        begin
            cnt   <= 0;
            flags <= 3'h7;
        end
        else if (check)
        begin
            cnt <= cnt + 1;
            if (cnt == DELAY)
                flags <= fail;
        end
        else
            flags <= alarm;
    end
endmodule : upper_monitor_model

`default_nettype wire

// [verification/cell_alarm_chain_monitor_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "chain_defs.svh"

// ****************************************
// Chain monitor bench
// ****************************************
module cell_alarm_chain_monitor_tb
    import chain_pkg::*;
;
    // Short ms keeps the 1000 ms test in reach
    localparam int MS = 10;
    logic        mclk = 1'h0, rst = 1'h1, head = 1'h1, base = 1'h1;
    logic        split = 1'h1, slp = 1'h0, wake = 1'h0, chk_in = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [2:0]  hc = 3'h0, up_alarm = 3'h0, up_fail = 3'h0, up;
    wire logic [2:0] lvl, snk;
    logic [5:0]  hcc = 6'h0, lcc = 6'h0;
    logic [1:0]  hat = 2'h3;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, wfwd, cfwd, rail, er;
    int          n_mismatch = 0, samples_checked = 0, i, m;

    cell_alarm_chain_monitor #(.MS_CYCLES(MS)) uut (
        .mclk(mclk), .rst(rst),
        .chain_head_strap(head), .chain_base_strap(base),
        .hold_code_b0(hc[2]), .hold_code_b1(hc[1]), .hold_code_b2(hc[0]),
        .alarm_split_sel(split), .thermistor_slope_sel(slp),
        .wake_in(wake), .check_req_in(chk_in),
        .high_cell_flag_from_up(up[0]), .low_cell_flag_from_up(up[1]),
        .heat_flag_from_up(up[2]),
        .high_cell_cond(hcc), .low_cell_cond(lcc), .heat_above_trip(hat),
        .high_cell_flag_level(lvl[0]), .low_cell_flag_level(lvl[1]),
        .heat_flag_level(lvl[2]),
        .high_cell_flag_sink_dn(snk[0]), .low_cell_flag_sink_dn(snk[1]),
        .heat_flag_sink_dn(snk[2]),
        .wake_fwd_out(wfwd), .check_req_fwd(cfwd), .rail_enable(rail),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    upper_monitor_model upper (
        .mclk(mclk), .wake(wfwd), .check(cfwd),
        .alarm(up_alarm), .fail(up_fail), .flags(up)
    );

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    function automatic logic [2:0] exp_al(input logic sp, input logic [2:0] c);
        return sp ? c : {3{|c}};
    endfunction : exp_al

    function automatic logic [31:0] exp_hold(input int c);
        int t[7] = '{0, 80, 625, 1250, 2500, 5000, 10000};
        return t[c];
    endfunction : exp_hold

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic note(input string s);
        $display("done: %s", s);
    endtask : note

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // Holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do
            @(posedge mclk);
        while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask : apb

    // Straps only move while reset is held
    task automatic reset_dut(input logic [1:0] p, input logic [2:0] c);
        {head, base} <= p;
        hc  <= c;
        rst <= 1'h1;
        repeat (16) @(posedge mclk);
        rst <= 1'h0;
        repeat (6) @(posedge mclk);
    endtask : reset_dut

    task automatic set_cond(input int ch, input logic v);
        int k;
        k = $urandom_range(5, 0);
        if (!v)
        begin
            hcc <= 6'h0;
            lcc <= 6'h0;
            hat <= {2{~slp}};
        end
        else if (ch == 0)
            hcc[k] <= 1'h1;
        else if (ch == 1)
            lcc[k] <= 1'h1;
        else
            hat[k % 2] <= slp;
    endtask : set_cond

    task automatic self_test(input int len, input logic [2:0] exp);
        chk_in <= 1'h1;
        repeat (6) @(posedge mclk);
        chk({lvl, snk, cfwd}, 7'h7f, "test start");
        apb(1'h0, `REG_STATUS, 32'h0);
        chk(rd[13:12], st_run, "test state");
        repeat (len - 50) @(posedge mclk);
        chk(lvl, 3'h7, "test busy");
        repeat (70) @(posedge mclk);
        chk({lvl, snk}, {exp, exp}, "result");
        chk_in <= 1'h0; // Pulse outlasts the
        repeat (8) @(posedge mclk);
        chk(lvl, 3'h0, "after test");
        note("self-test");
    endtask : self_test

    initial
    begin
        repeat (60000) @(posedge mclk);
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end

    initial
    begin
        void'($urandom(32'ha6bb0708));
        for (i = 0; i < 7; i++) // Code 111 stays unused
        begin
            reset_dut(i[1:0], i[2:0]);
            apb(1'h0, `REG_HOLD, 32'h0);
            chk(rd, exp_hold(i), "hold");
            apb(1'h0, `REG_STATUS, 32'h0);
            chk(rd[1:0], i[1:0], "position");
            chk({lvl, snk, rail}, 7'h0, "standby");
        end
        apb(1'h0, 12'h00c, 32'h0);
        chk(er, 1'h1, "unmapped");
        apb(1'h1, `REG_CTRL, 32'h5);
        apb(1'h0, `REG_CTRL, 32'h0);
        chk(rd, 32'h5, "ctrl");
        apb(1'h1, `REG_CTRL, 32'h0);
        note("registers");
        reset_dut(2'h1, 3'h0);
        wake <= 1'h1; // Base takes the controller levels
        repeat (6) @(posedge mclk);
        chk({rail, wfwd}, 2'h3, "wake");
        for (m = 0; m < 4; m++)
        begin
            split <= m[0];
            slp   <= m[1];
            hat   <= {2{~m[1]}};
            repeat (8) @(posedge mclk);
            for (i = 0; i < 3; i++)
            begin
                set_cond(i, 1'h1);
                repeat (8) @(posedge mclk);
                chk({lvl, snk}, {2{exp_al(m[0], 3'h1 << i)}}, "alarm");
                set_cond(i, 1'h0);
                repeat (8) @(posedge mclk);
                chk(lvl, 3'h0, "clear");
            end
        end
        note("alarms");
        split <= 1'h1;
        reset_dut(2'h0, 3'h0);
        up_alarm <= 3'($urandom_range(7, 1));
        repeat (8) @(posedge mclk);
        chk({lvl, wfwd}, {up_alarm, 1'h1}, "from up");
        hcc[0] <= 1'h1;
        wake   <= 1'h0;
        repeat (8) @(posedge mclk);
        chk({lvl, rail, wfwd}, 5'h0, "asleep");
        hcc[0] <= 1'h0;
        wake   <= 1'h1;
        reset_dut(2'h2, 3'h0);
        chk(lvl, 3'h0, "head");
        up_alarm <= 3'h0;
        note("chain");
        reset_dut(2'h1, 3'h1);
        hcc[0] <= 1'h1;
        repeat (400) @(posedge mclk);
        hcc[0] <= 1'h0;
        repeat (20) @(posedge mclk);
        chk(lvl, 3'h0, "glitch");
        hcc[0] <= 1'h1;
        repeat (80 * MS) @(posedge mclk);
        chk(lvl, 3'h0, "early");
        repeat (40) @(posedge mclk);
        chk(lvl, 3'h1, "held");
        hcc[0] <= 1'h0;
        repeat (8) @(posedge mclk);
        note("hold");
        self_test(1000 * MS, 3'h0);
        reset_dut(2'h1, 3'h0);
        self_test(25 * MS, 3'h0);
        up_fail <= 3'h3;
        self_test(25 * MS, exp_al(1'h1, 3'h3));
        up_fail <= 3'h0;
        apb(1'h1, `REG_CTRL, 32'h1);
        self_test(25 * MS, exp_al(1'h1, 3'h1));
        split <= 1'h0;
        repeat (8) @(posedge mclk);
        self_test(25 * MS, exp_al(1'h0, 3'h1));
        final_report();
    end
endmodule : cell_alarm_chain_monitor_tb

`default_nettype wire
